//--- design/dual_dac_serial_load_control.v
// serial load control of a dual dac: frame receiver, buffering, pin control, avalon registers
//
// Functional notes
// RULE_01 - clear zeroes input and output registers
// RULE_02 - load-outputs copies input into output registers
// RULE_03 - one load pulse updates channels with new data
// RULE_04 - frame select fall starts a write frame
// RULE_05 - sample serial-in on next 16 clock falls
// RULE_06 - early frame end aborts, registers unchanged
// RULE_07 - sixteen-bit shift register, shifts on falling edges
// RULE_08 - host keeps shift clock at most 30 MHz
// RULE_09 - after a frame, ignore clock and data
// RULE_10 - bits leaving shift register go to serial-out
// RULE_11 - serial-out valid at the falling clock edge
// RULE_12 - cascade only while chain enable is high
// RULE_13 - sleep pin powers down both, outputs hi-z
// RULE_14 - per-channel pin selects buffered or unbuffered reference
// RULE_15 - output codes are straight binary of RES_BITS
// RULE_16 - word decodes to channel, power mode, data
// RULE_17 - clear acts at once, overrides any frame
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "dual_dac_map.vh"
module dual_dac_serial_load_control #(
    parameter RES_BITS = 12,
    parameter FRAME_BITS = 16
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_srst,
    // serial link pins
    input wire i_frame_n,
    input wire i_sclk,
    input wire i_sdin,
    output wire o_serial_out,
    output wire o_serial_out_en,
    // control pins
    input wire i_clear_n,
    input wire i_load_outputs_n,
    input wire i_chain_enable,
    input wire i_hw_sleep_n,
    input wire i_buf_a,
    input wire i_buf_b,
    // avalon-mm slave
    input wire [4:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output wire [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // converter side
    output wire [RES_BITS-1:0] o_code_a,
    output wire [RES_BITS-1:0] o_code_b,
    output reg [1:0] o_pd_mode_a,
    output reg [1:0] o_pd_mode_b,
    output reg o_out_hiz_a,
    output reg o_out_hiz_b,
    output reg o_ref_buffered_a,
    output reg o_ref_buffered_b
);
    localparam CW = 5;
    localparam [31:0] FRAME_W = FRAME_BITS;
    localparam [31:0] LAST_W = FRAME_BITS - 1;
    localparam [CW-1:0] LAST_BIT = LAST_W[CW-1:0];
    localparam [CW-1:0] FULL_CNT = FRAME_W[CW-1:0];
    localparam [CW-1:0] MAX_CNT = {CW{1'b1}};

    // pins into the clock domain
    wire frame_n_s;
    wire sclk_s;
    wire sdin_s;
    wire clear_n_s;
    wire load_n_s;
    wire chain_s;
    wire sleep_n_s;
    wire buf_a_s;
    wire buf_b_s;

    pin_sync #(
        .W(9),
        .RST_VAL(9'h1b4)
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_async({i_frame_n, i_sclk, i_sdin, i_clear_n, i_load_outputs_n,
                  i_chain_enable, i_hw_sleep_n, i_buf_a, i_buf_b}),
        .o_sync({frame_n_s, sclk_s, sdin_s, clear_n_s, load_n_s,
                 chain_s, sleep_n_s, buf_a_s, buf_b_s})
    );

    // software control
    reg soft_clear_q;
    reg soft_load_q;
    reg frame_block_q;
    wire clear_all = ~clear_n_s | soft_clear_q;
    wire load_all = ~load_n_s | soft_load_q;

    // edge detection on synchronised levels
    reg frame_prev_q;
    reg sclk_prev_q;
    wire frame_fall = frame_prev_q & ~frame_n_s;
    wire frame_rise = ~frame_prev_q & frame_n_s;
    wire sclk_fall = sclk_prev_q & ~sclk_s;

    // frame receiver state
    reg active_q;
    reg active_d;
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;
    reg [FRAME_BITS-1:0] sh_q;
    reg [FRAME_BITS-1:0] sh_d;
    reg sdo_q;
    reg sdo_d;
    reg commit_d;
    reg abort_d;
    reg [FRAME_BITS-1:0] word_d;
    reg commit_q;
    reg [FRAME_BITS-1:0] word_q;
    reg [15:0] done_cnt_q;
    reg [15:0] abort_cnt_q;

    always @* begin
        active_d = active_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        sdo_d = sdo_q;
        commit_d = 1'b0;
        abort_d = 1'b0;
        word_d = sh_q;
        if (clear_all) begin
            active_d = 1'b0; // [RULE_17]
        end else if (frame_fall && !frame_block_q) begin
            active_d = 1'b1; // [RULE_04]
            cnt_d = {CW{1'b0}};
        end else if (frame_rise && active_q) begin
            active_d = 1'b0;
            if (chain_s && cnt_q >= FULL_CNT) begin
                commit_d = 1'b1; // [RULE_12]
            end else begin
                abort_d = 1'b1; // [RULE_06]
            end
        end else if (active_q && sclk_fall && !frame_n_s) begin
            sh_d = {sh_q[FRAME_BITS-2:0], sdin_s}; // [RULE_05] [RULE_07]
            // next bit to leave stands before the following fall
            sdo_d = sh_q[FRAME_BITS-2]; // [RULE_10] [RULE_11]
            if (cnt_q != MAX_CNT) cnt_d = cnt_q + 1'b1;
            if (!chain_s && cnt_q == LAST_BIT) begin
                commit_d = 1'b1;
                word_d = sh_d;
                active_d = 1'b0; // [RULE_09]
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            frame_prev_q <= 1'b1;
            sclk_prev_q <= 1'b1;
            active_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
            sh_q <= {FRAME_BITS{1'b0}};
            sdo_q <= 1'b0;
            commit_q <= 1'b0;
            word_q <= {FRAME_BITS{1'b0}};
            done_cnt_q <= 16'h0000;
            abort_cnt_q <= 16'h0000;
        end else begin
            frame_prev_q <= frame_n_s;
            sclk_prev_q <= sclk_s;
            active_q <= active_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            sdo_q <= sdo_d;
            commit_q <= commit_d & ~clear_all;
            if (commit_d) begin
                word_q <= word_d;
                done_cnt_q <= done_cnt_q + 16'h0001;
            end
            if (abort_d) abort_cnt_q <= abort_cnt_q + 16'h0001;
        end
    end

    assign o_serial_out = sdo_q;
    assign o_serial_out_en = chain_s; // [RULE_12]

    // word decode
    wire word_sel_b = word_q[`WORD_CHAN_BIT]; // [RULE_16]
    wire [1:0] word_pd = word_q[`WORD_PD_MSB:`WORD_PD_LSB];
    wire [RES_BITS-1:0] word_code = word_q[`WORD_DATA_MSB -: RES_BITS]; // [RULE_15]

    wire [RES_BITS-1:0] in_a;
    wire [RES_BITS-1:0] in_b;
    wire new_a;
    wire new_b;

    dac_code_regs #(
        .W(RES_BITS)
    ) u_code_regs (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_clear(clear_all), // [RULE_01]
        .i_load(load_all), // [RULE_02] [RULE_03]
        .i_wr_stb(commit_q),
        .i_wr_sel_b(word_sel_b),
        .i_wr_code(word_code),
        .o_in_a(in_a),
        .o_in_b(in_b),
        .o_out_a(o_code_a),
        .o_out_b(o_code_b),
        .o_new_a(new_a),
        .o_new_b(new_b)
    );

    // power-down state and pin-driven outputs
    reg [1:0] pd_a_q;
    reg [1:0] pd_b_q;

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            pd_a_q <= `PD_NORMAL;
            pd_b_q <= `PD_NORMAL;
            o_pd_mode_a <= `PD_NORMAL;
            o_pd_mode_b <= `PD_NORMAL;
            o_out_hiz_a <= 1'b0;
            o_out_hiz_b <= 1'b0;
            o_ref_buffered_a <= 1'b0;
            o_ref_buffered_b <= 1'b0;
        end else begin
            if (commit_q && !word_sel_b) pd_a_q <= word_pd; // [RULE_16]
            if (commit_q && word_sel_b) pd_b_q <= word_pd;
            o_pd_mode_a <= sleep_n_s ? pd_a_q : `PD_HIZ; // [RULE_13]
            o_pd_mode_b <= sleep_n_s ? pd_b_q : `PD_HIZ;
            o_out_hiz_a <= ~sleep_n_s | (pd_a_q == `PD_HIZ);
            o_out_hiz_b <= ~sleep_n_s | (pd_b_q == `PD_HIZ);
            o_ref_buffered_a <= buf_a_s; // [RULE_14]
            o_ref_buffered_b <= buf_b_s;
        end
    end

    // avalon slave: one wait state, then read data from a flop
    reg ack_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    wire req = i_avs_read | i_avs_write;
    wire wr_take = i_avs_write & ack_q;

    assign o_avs_waitrequest = req & ~ack_q;
    assign o_avs_readdata = rdata_q;

    always @* begin
        rdata_d = 32'h0000_0000;
        if (i_avs_address == `REG_CTRL) begin
            rdata_d[`CTRL_FRAME_BLOCK] = frame_block_q;
        end else if (i_avs_address == `REG_STATUS) begin
            rdata_d[`ST_ACTIVE] = active_q;
            rdata_d[`ST_CNT_MSB:`ST_CNT_LSB] = cnt_q;
            rdata_d[`ST_NEW_A] = new_a;
            rdata_d[`ST_NEW_B] = new_b;
            rdata_d[`ST_SLEEP] = ~sleep_n_s;
            rdata_d[`ST_CHAIN] = chain_s;
            rdata_d[`ST_BUF_A] = buf_a_s;
            rdata_d[`ST_BUF_B] = buf_b_s;
            rdata_d[`ST_CLEAR] = ~clear_n_s;
        end else if (i_avs_address == `REG_LAST_WORD) begin
            rdata_d[FRAME_BITS-1:0] = word_q;
        end else if (i_avs_address == `REG_CODE_A) begin
            rdata_d[RES_BITS-1:0] = in_a;
            rdata_d[`CODE_OUT_LSB +: RES_BITS] = o_code_a;
        end else if (i_avs_address == `REG_CODE_B) begin
            rdata_d[RES_BITS-1:0] = in_b;
            rdata_d[`CODE_OUT_LSB +: RES_BITS] = o_code_b;
        end else if (i_avs_address == `REG_FRAME_CNT) begin
            rdata_d = {abort_cnt_q, done_cnt_q};
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            soft_clear_q <= 1'b0;
            soft_load_q <= 1'b0;
            frame_block_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
            if (i_avs_read && !ack_q) rdata_q <= rdata_d;
            soft_clear_q <= 1'b0;
            soft_load_q <= 1'b0;
            if (wr_take && i_avs_address == `REG_CTRL && i_avs_byteenable[0]) begin
                soft_clear_q <= i_avs_writedata[`CTRL_SOFT_CLEAR];
                soft_load_q <= i_avs_writedata[`CTRL_SOFT_LOAD];
                frame_block_q <= i_avs_writedata[`CTRL_FRAME_BLOCK];
            end
        end
    end
endmodule // dual_dac_serial_load_control

//--- design/dual_dac_map.vh
// register offsets, field layouts and encodings of the dual dac load control
`ifndef DUAL_DAC_MAP_VH
`define DUAL_DAC_MAP_VH

// avalon byte offsets
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_LAST_WORD 5'h08
`define REG_CODE_A 5'h0c
`define REG_CODE_B 5'h10
`define REG_FRAME_CNT 5'h14

// control register bits
`define CTRL_SOFT_CLEAR 0
`define CTRL_SOFT_LOAD 1
`define CTRL_FRAME_BLOCK 2

// status register bits
`define ST_ACTIVE 0
`define ST_CNT_LSB 1
`define ST_CNT_MSB 5
`define ST_NEW_A 8
`define ST_NEW_B 9
`define ST_SLEEP 10
`define ST_CHAIN 11
`define ST_BUF_A 12
`define ST_BUF_B 13
`define ST_CLEAR 14

// code registers: input code low half, output code high half
`define CODE_OUT_LSB 16

// command word layout
`define WORD_CHAN_BIT 15
`define WORD_PD_MSB 14
`define WORD_PD_LSB 13
`define WORD_DATA_MSB 11

// power-down modes
`define PD_NORMAL 2'h0
`define PD_PULL_1K 2'h1
`define PD_PULL_100K 2'h2
`define PD_HIZ 2'h3

`endif

//--- design/pin_sync.v
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_srst,
    // pins in, synchronised levels out
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // pin_sync

//--- design/dac_code_regs.v
// double-buffered input and output code registers of both channels
`timescale 1ns/1ps
module dac_code_regs #(
    parameter W = 12
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_srst,
    // control
    input wire i_clear,
    input wire i_load,
    // word write
    input wire i_wr_stb,
    input wire i_wr_sel_b,
    input wire [W-1:0] i_wr_code,
    // register contents
    output reg [W-1:0] o_in_a,
    output reg [W-1:0] o_in_b,
    output reg [W-1:0] o_out_a,
    output reg [W-1:0] o_out_b,
    output reg o_new_a,
    output reg o_new_b
);
    wire wr_a = i_wr_stb & ~i_wr_sel_b;
    wire wr_b = i_wr_stb & i_wr_sel_b;
    wire [W-1:0] in_a_d = wr_a ? i_wr_code : o_in_a;
    wire [W-1:0] in_b_d = wr_b ? i_wr_code : o_in_b;

    always @(posedge i_sys_clk) begin
        if (i_srst || i_clear) begin
            o_in_a <= {W{1'b0}}; // [RULE_01] [RULE_17]
            o_in_b <= {W{1'b0}};
            o_out_a <= {W{1'b0}};
            o_out_b <= {W{1'b0}};
            o_new_a <= 1'b0;
            o_new_b <= 1'b0;
        end else begin
            o_in_a <= in_a_d;
            o_in_b <= in_b_d;
            // a word landing during a held load passes straight through
            if (i_load) begin
                if (o_new_a || wr_a) o_out_a <= in_a_d; // [RULE_02] [RULE_03]
                if (o_new_b || wr_b) o_out_b <= in_b_d;
                o_new_a <= 1'b0;
                o_new_b <= 1'b0;
            end else begin
                o_new_a <= o_new_a | wr_a;
                o_new_b <= o_new_b | wr_b;
            end
        end
    end
endmodule // dac_code_regs

//--- verification/dual_dac_chk.sv
// pin-level assertions on the dual dac serial load control
`timescale 1ns/1ps
module dual_dac_chk #(
    parameter RES_BITS = 12
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_srst,
    // bus and pins
    input wire i_avs_read,
    input wire i_avs_write,
    input wire o_avs_waitrequest,
    input wire i_clear_n,
    input wire i_load_outputs_n,
    input wire i_hw_sleep_n,
    input wire i_chain_enable,
    input wire i_buf_a,
    // converter side
    input wire [RES_BITS-1:0] o_code_a,
    input wire [RES_BITS-1:0] o_code_b,
    input wire [1:0] o_pd_mode_a,
    input wire [1:0] o_pd_mode_b,
    input wire o_out_hiz_a,
    input wire o_out_hiz_b,
    input wire o_serial_out_en,
    input wire o_ref_buffered_a
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer late");
    a_clear_zero: assert property (!i_clear_n [*5] |-> o_code_a == 0 && o_code_b == 0)
        else $error("codes not cleared");
    a_code_hold: assert property (i_load_outputs_n [*5] and i_clear_n [*5] and !i_avs_write [*5]
        |-> $stable(o_code_a) && $stable(o_code_b))
        else $error("code moved without load");
    a_sleep_hiz: assert property (!i_hw_sleep_n [*6] |-> o_out_hiz_a && o_out_hiz_b
        && o_pd_mode_a == 2'h3 && o_pd_mode_b == 2'h3)
        else $error("sleep not applied");
    a_ref_buf: assert property (i_buf_a [*4] |-> o_ref_buffered_a)
        else $error("reference a not buffered");
    a_ref_unbuf: assert property (!i_buf_a [*4] |-> !o_ref_buffered_a)
        else $error("reference a not unbuffered");
    a_chain_on: assert property (i_chain_enable [*4] |-> o_serial_out_en)
        else $error("serial out not enabled");
    a_chain_off: assert property (!i_chain_enable [*4] |-> !o_serial_out_en)
        else $error("serial out enabled standalone");
    c_clear: cover property (!i_clear_n [*5]);
    c_sleep: cover property (!i_hw_sleep_n [*6]);
    c_chain: cover property (i_chain_enable && o_serial_out_en);
endmodule // dual_dac_chk

//--- verification/dac_host_model.sv
// behavioural host driving the three-wire link and capturing serial-out
`timescale 1ns/1ps
module dac_host_model (
    // link pins
    output reg o_frame_n,
    output reg o_sclk,
    output reg o_sdin,
    input wire i_serial_out
);
    reg [15:0] rx_q;
    initial begin
        o_frame_n = 1'b1;
        o_sclk = 1'b1;
        o_sdin = 1'b0;
        rx_q = 16'h0;
    end
    // n falls, msb first; bits past the 16th go out inverted
    task send(input [15:0] w, input integer n);
        integer i;
        begin
            #7 o_frame_n = 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                o_sdin = w[15 - (i % 16)] ^ (i >= 16);
                #100 o_sclk = 1'b0; // 5 MHz, below the limit
                rx_q = {rx_q[14:0], i_serial_out}; // read on the fall
                #100 o_sclk = 1'b1;
            end
            #100 o_frame_n = 1'b1;
            o_sdin = ~o_sdin; // released line shows no stale bit
            #400;
        end
    endtask
endmodule // dac_host_model

//--- verification/tb.sv
// self-checking bench of the dual dac serial load control
`timescale 1ns/1ps
module tb;
    reg clk, srst, clr_n, ld_n, chain, slp_n, buf_a, buf_b, rd, wr;
    reg [4:0] adr;
    reg [31:0] wd, q;
    wire fr_n, sclk, sdin, sout, sout_en, wtr, hz_a, hz_b, rb_a, rb_b;
    wire [31:0] rdata;
    wire [11:0] code_a, code_b;
    wire [1:0] pd_a, pd_b;
    integer mismatches, checks, m;
    dac_host_model host (.o_frame_n(fr_n), .o_sclk(sclk), .o_sdin(sdin), .i_serial_out(sout));
    dual_dac_serial_load_control uut (
        .i_sys_clk(clk), .i_srst(srst), .i_frame_n(fr_n), .i_sclk(sclk), .i_sdin(sdin),
        .o_serial_out(sout), .o_serial_out_en(sout_en), .i_clear_n(clr_n), .i_load_outputs_n(ld_n),
        .i_chain_enable(chain), .i_hw_sleep_n(slp_n), .i_buf_a(buf_a), .i_buf_b(buf_b),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wtr),
        .o_code_a(code_a), .o_code_b(code_b), .o_pd_mode_a(pd_a), .o_pd_mode_b(pd_b),
        .o_out_hiz_a(hz_a), .o_out_hiz_b(hz_b), .o_ref_buffered_a(rb_a), .o_ref_buffered_b(rb_b)
    );
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [4:0] a, input [31:0] d, output [31:0] r);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            rd <= !w;
            wr <= w;
            adr <= a;
            wd <= d;
            @(posedge clk);
            while (wtr !== 1'b0 && n < 20) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n == 20) mismatches = mismatches + 1;
            r = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task stop_test;
        begin
            $display("mismatches=%0d checks=%0d", mismatches, checks);
            if (mismatches == 0 && checks > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #500000;
        mismatches = mismatches + 1;
        stop_test;
    end
    initial begin
        {srst, clr_n, ld_n, slp_n, buf_a} = 5'h1f;
        {chain, buf_b, rd, wr, adr, wd} = 0;
        mismatches = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        // pins need two edges through the synchroniser
        repeat (4) @(posedge clk);
        bus(0, 5'h04, 0, q);
        cmp(q, 32'h1000);
        bus(0, 5'h18, 0, q);
        cmp(q, 0);
        bus(1, 5'h08, 32'hffff, q);
        bus(0, 5'h08, 0, q);
        cmp(q, 0);
        bus(1, 5'h00, 32'h4, q);
        bus(0, 5'h00, 0, q);
        cmp(q, 32'h4);
        bus(1, 5'h00, 32'h0, q);
        host.send(16'h05a3, 16);
        bus(0, 5'h0c, 0, q);
        cmp(q, 32'h05a3);
        host.send(16'h8c3e, 16);
        cmp({20'h0, code_b}, 0);
        @(posedge clk) ld_n <= 1'b0;
        repeat (4) @(posedge clk);
        ld_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmp({8'h0, code_a, code_b}, 32'h5a3c3e);
        host.send(16'h0111, 10);
        bus(0, 5'h0c, 0, q);
        cmp(q, 32'h05a305a3);
        host.send(16'h0123, 20);
        bus(0, 5'h0c, 0, q);
        cmp(q, 32'h05a30123);
        for (m = 3; m >= 0; m = m - 1) begin
            host.send({1'b1, m[1:0], 1'b0, 12'hc3e}, 16);
            cmp({30'h0, pd_b}, m);
        end
        @(posedge clk) slp_n <= 1'b0;
        repeat (8) @(posedge clk);
        cmp({26'h0, hz_a, hz_b, pd_a, pd_b}, 32'h3f);
        slp_n <= 1'b1;
        buf_a <= 1'b0;
        buf_b <= 1'b1;
        repeat (8) @(posedge clk);
        cmp({28'h0, pd_b, rb_a, rb_b}, 32'h1);
        clr_n <= 1'b0;
        repeat (6) @(posedge clk);
        cmp({8'h0, code_a, code_b}, 0);
        clr_n <= 1'b1;
        fork
            host.send(16'h0777, 16);
            begin
                repeat (40) @(posedge clk);
                clr_n <= 1'b0;
                repeat (6) @(posedge clk);
                clr_n <= 1'b1;
            end
        join
        bus(0, 5'h0c, 0, q);
        cmp(q, 0);
        @(posedge clk) chain <= 1'b1;
        repeat (4) @(posedge clk);
        host.send(16'h7abc, 32);
        cmp({16'h0, host.rx_q}, 32'h7abc);
        bus(0, 5'h10, 0, q);
        cmp(q, 32'h0543);
        bus(0, 5'h08, 0, q);
        cmp(q, 32'h8543);
        bus(0, 5'h14, 0, q);
        cmp(q, 32'h00010008);
        chain <= 1'b0;
        bus(1, 5'h00, 32'h2, q);
        bus(0, 5'h10, 0, q);
        cmp(q, 32'h05430543);
        bus(1, 5'h00, 32'h1, q);
        bus(0, 5'h10, 0, q);
        cmp(q, 0);
        stop_test;
    end
endmodule // tb
bind dual_dac_serial_load_control dual_dac_chk #(.RES_BITS(RES_BITS)) chk (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest), .i_clear_n(i_clear_n), .i_load_outputs_n(i_load_outputs_n),
    .i_hw_sleep_n(i_hw_sleep_n), .i_chain_enable(i_chain_enable), .i_buf_a(i_buf_a),
    .o_code_a(o_code_a), .o_code_b(o_code_b), .o_pd_mode_a(o_pd_mode_a), .o_pd_mode_b(o_pd_mode_b),
    .o_out_hiz_a(o_out_hiz_a), .o_out_hiz_b(o_out_hiz_b), .o_serial_out_en(o_serial_out_en),
    .o_ref_buffered_a(o_ref_buffered_a)
);
